// ---- shared/fhr_cfg.svh ----
// Purpose: constants for the floppy host register interface
// Assumes: byte registers, one per aligned 32-bit word on Avalon-MM
// Notes: register offsets are word indices; the byte address is index times four
`ifndef FHR_CFG_SVH
`define FHR_CFG_SVH
`define FHR_IDX_DOC 3'h2
`define FHR_IDX_TSC 3'h3
`define FHR_IDX_MST 3'h4
`define FHR_IDX_DAT 3'h5
`define FHR_IDX_DIS 3'h7
`define FHR_IDX_DRV 3'h6
`define FHR_RATE_RST 8'h02
`define FHR_B_RST 7
`define FHR_B_PWR 6
`define FHR_B_MOTB 5
`define FHR_B_MOTA 4
`define FHR_B_GATE 3
`define FHR_B_CRST 2
`define FHR_B_PICK 0
`define FHR_DIV_1M 4'h0
`define FHR_DIV_500K 4'h1
`define FHR_DIV_300K 4'h2
`define FHR_DIV_250K 4'h3
`define FHR_PC_DEF1M 4'h1
`define FHR_PC_DEF 4'h3
`endif

// ---- shared/fhr_pkg.sv ----
// Purpose: types for the floppy host register interface
// Assumes: nothing beyond the cfg header
// Notes: rate codes as stored in the rate field
package fhr_pkg;
   typedef enum logic [1:0] {
      FHR_R500K = 2'h0,
      FHR_R300K = 2'h1,
      FHR_R250K = 2'h2,
      FHR_R1M = 2'h3
   } fhr_rate_type;
   typedef enum logic [2:0] {
      FHR_IDLE = 3'h1,
      FHR_WAIT = 3'h2,
      FHR_DONE = 3'h4
   } fhr_bus_type;
endpackage

// ---- rtl/fhr_regs.sv ----
// Purpose: host register set of a two-drive floppy controller
// Assumes: one clock, core engine outside feeds status and stack bytes
// Notes: answers every access one cycle after it is seen
`timescale 1ns/100ps
`include "fhr_cfg.svh"
module fhr_regs (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // avalon-mm slave
   input wire logic [4:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // core engine status, same clock; disk change is a drive pin
   input wire logic i_transfer_request_flag,
   input wire logic i_transfer_direction_flag,
   input wire logic i_non_dma_flag,
   input wire logic i_command_busy_flag,
   input wire logic i_second_drive_seek_busy,
   input wire logic i_first_drive_seek_busy,
   input wire logic [7:0] i_stack_rd_data,
   input wire logic i_disk_change_n,
   input wire logic i_core_irq,
   input wire logic i_core_drq,
   // core engine controls
   output logic o_core_reset,
   output logic o_stack_pop,
   output logic o_stack_push,
   output logic [7:0] o_stack_wr_data,
   output logic [1:0] o_rate_code,
   output logic [3:0] o_sep_clk_div,
   output logic [3:0] o_precomp_step,
   output logic o_power_down,
   // drive and system side
   output logic o_first_motor_enable,
   output logic o_second_motor_enable,
   output logic o_drive_pick,
   output logic o_irq,
   output logic o_drq
);
   // register state
   logic [7:0] doc_r, doc_nxt;
   logic [1:0] tsc_r, tsc_nxt;
   logic [6:0] rps_r, rps_nxt;
   logic rrst_r, rrst_nxt;
   logic pwr_r, pwr_nxt;
   logic [7:0] rd_r, rd_nxt;
   logic ack_r;
   logic [1:0] rate_r, rate_nxt;
   logic sep_r1, sep_r2;
   logic dchg_s1, dchg_s2;
   // hardware reset value of the rate select byte
   localparam logic [7:0] rate_rst_v = `FHR_RATE_RST;
   fhr_pkg::fhr_bus_type st_r, st_nxt;

   // decode of the word index
   wire logic [2:0] idx = i_address[4:2];
   wire logic hit = i_address[4:2] != 3'h0 && i_address[1:0] == 2'h0;
   wire logic wr_go = i_write && !ack_r && i_byteenable[0] && hit;
   wire logic rd_go = i_read && !ack_r && hit;
   wire logic [7:0] wd = i_writedata[7:0];
   wire logic wr_doc = wr_go && idx == `FHR_IDX_DOC;
   wire logic wr_tsc = wr_go && idx == `FHR_IDX_TSC;
   wire logic wr_rps = wr_go && idx == `FHR_IDX_MST;
   wire logic wr_dat = wr_go && idx == `FHR_IDX_DAT;
   wire logic wr_drc = wr_go && idx == `FHR_IDX_DIS;
   wire logic rd_dat = rd_go && idx == `FHR_IDX_DAT;
   wire logic rd_mst = rd_go && idx == `FHR_IDX_MST;

   // status byte; reserved bits 3:2 read zero
   wire logic [7:0] mst = {i_transfer_request_flag,
      i_transfer_direction_flag,
      i_non_dma_flag,
      i_command_busy_flag,
      2'h0,
      i_second_drive_seek_busy,
      i_first_drive_seek_busy};

   // precompensation step in 41.7 ns units, code 000 follows the rate
   function automatic logic [3:0] pc_step(input logic [2:0] c,
         input logic [1:0] r);
      logic [3:0] s;
      s = {1'b0, c};
      if (c == 3'h7)
         s = 4'h0;
      else if (c == 3'h0)
         s = (r == fhr_pkg::FHR_R1M) ? `FHR_PC_DEF1M : `FHR_PC_DEF;
      return s;
   endfunction

   // separator divider per rate code
   function automatic logic [3:0] sep_div(input logic [1:0] r);
      logic [3:0] d;
      case (r)
         fhr_pkg::FHR_R500K: d = `FHR_DIV_500K;
         fhr_pkg::FHR_R300K: d = `FHR_DIV_300K;
         fhr_pkg::FHR_R250K: d = `FHR_DIV_250K;
         default: d = `FHR_DIV_1M;
      endcase
      return d;
   endfunction

   // read mux: unmapped offsets read as zero
   always_comb begin
      case (idx)
         `FHR_IDX_DOC: rd_nxt = doc_r;
         `FHR_IDX_TSC: rd_nxt = {6'h0, tsc_r};
         `FHR_IDX_MST: rd_nxt = mst;
         `FHR_IDX_DAT: rd_nxt = i_stack_rd_data;
         `FHR_IDX_DIS: rd_nxt = {~dchg_s2, 7'h0};
         default: rd_nxt = 8'h0;
      endcase
   end

   // next register values
   always_comb begin
      doc_nxt = wr_doc ? wd : doc_r;
      tsc_nxt = wr_tsc ? wd[1:0] : tsc_r;
      rps_nxt = wr_rps ? wd[6:0] : rps_r;
      // rate reset clears itself one cycle after taking effect
      rrst_nxt = wr_rps & wd[`FHR_B_RST];
      rate_nxt = rate_r;
      if (wr_rps)
         rate_nxt = wd[1:0];
      else if (wr_drc)
         rate_nxt = wd[1:0];
      pwr_nxt = pwr_r;
      if (wr_rps)
         pwr_nxt = wd[`FHR_B_PWR];
      else if (rd_dat || rd_mst || wr_dat || o_core_reset)
         pwr_nxt = 1'b0;
   end

   // bus handshake state: one wait cycle, then answer
   always_comb begin
      case (st_r)
         fhr_pkg::FHR_IDLE: st_nxt = (i_read || i_write) ?
            fhr_pkg::FHR_WAIT : fhr_pkg::FHR_IDLE;
         fhr_pkg::FHR_WAIT: st_nxt = fhr_pkg::FHR_DONE;
         fhr_pkg::FHR_DONE: st_nxt = fhr_pkg::FHR_IDLE;
         default: st_nxt = fhr_pkg::FHR_IDLE;
      endcase
   end

   // output control is cleared by the interface reset
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         doc_r <= 8'h0;
         tsc_r <= 2'h0;
         rps_r <= rate_rst_v[6:0];
         rate_r <= rate_rst_v[1:0];
         rrst_r <= 1'b0;
         pwr_r <= 1'b0;
      end else begin
         doc_r <= doc_nxt;
         tsc_r <= tsc_nxt;
         rps_r <= rps_nxt; // software resets leave it alone
         rate_r <= rate_nxt;
         rrst_r <= rrst_nxt;
         pwr_r <= pwr_nxt;
      end
   end

   // bus side flops; access effect happens in the first cycle only
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_r <= 1'b0;
         rd_r <= 8'h0;
         st_r <= fhr_pkg::FHR_IDLE;
      end else begin
         ack_r <= (i_read || i_write) && !ack_r;
         rd_r <= rd_nxt;
         st_r <= st_nxt;
      end
   end

   // disk change is a drive pin: two flops before anything reads it
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         dchg_s1 <= 1'b1;
         dchg_s2 <= 1'b1;
      end else begin
         dchg_s1 <= i_disk_change_n;
         dchg_s2 <= dchg_s1;
      end
   end

   // pipeline the separator change two flops deep; sep_r2 comes one cycle after the rate updates
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sep_r1 <= 1'b0;
         sep_r2 <= 1'b0;
      end else begin
         sep_r1 <= wr_rps || wr_drc;
         sep_r2 <= sep_r1;
      end
   end

   // answer: waitrequest drops the cycle after the request is seen
   assign o_waitrequest = (i_read || i_write) && !ack_r;
   assign o_readdata = {24'h0, rd_r};

   // core reset: either source; output-control reset is a level that
   // holds until written back, rate-select reset lasts one cycle
   assign o_core_reset = !doc_r[`FHR_B_CRST] || rrst_r;
   // stack strobes, one entry per access; suppressed under reset
   assign o_stack_pop = rd_dat && !o_core_reset;
   assign o_stack_push = wr_dat && !o_core_reset;
   assign o_stack_wr_data = wd;
   assign o_rate_code = rate_r;
   assign o_sep_clk_div = sep_div(rate_r);
   assign o_precomp_step = pc_step(rps_r[4:2], rate_r);
   assign o_power_down = pwr_r;

   // drive outputs and gated interrupt / dma
   assign o_first_motor_enable = doc_r[`FHR_B_MOTA];
   assign o_second_motor_enable = doc_r[`FHR_B_MOTB];
   assign o_drive_pick = doc_r[`FHR_B_PICK];
   assign o_irq = doc_r[`FHR_B_GATE] && i_core_irq;
   assign o_drq = doc_r[`FHR_B_GATE] && i_core_drq;

   // the core-side timing registers live in the engine and are
   // not reset by this block; it resets only what it owns

   a_rate_selfclr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rrst_r |=> !rrst_r) else $error("rate reset did not clear");
   a_doc_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (!doc_r[`FHR_B_CRST] && !wr_doc) |=> o_core_reset)
      else $error("output reset released");
   a_rate_last: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_drc |=> o_rate_code == $past(wd[1:0]))
      else $error("rate not from last write");
   a_irq_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !doc_r[`FHR_B_GATE] |-> !o_irq && !o_drq)
      else $error("gate leak");
   a_pwr_wake: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (rd_mst && !wr_rps) |=> !o_power_down)
      else $error("no wake on status read");
   a_wait_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_read && !ack_r) |=> !o_waitrequest)
      else $error("late answer");
   a_mot_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_doc |=> o_first_motor_enable == $past(wd[`FHR_B_MOTA]))
      else $error("motor bit wrong");
   a_sep_track: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      sep_r2 |-> (o_rate_code != fhr_pkg::FHR_R1M ||
      o_sep_clk_div == `FHR_DIV_1M))
      else $error("separator not rescaled");
   a_mst_map: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rd_mst |=> o_readdata[7] == $past(i_transfer_request_flag))
      else $error("status bit 7 wrong");

   // precompensation decode against the fixed delay table
   a_pc_none: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rps_r[4:2] == 3'h7 |-> o_precomp_step == 4'h0)
      else $error("precomp none wrong");
   a_pc_plain: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (rps_r[4:2] != 3'h7 && rps_r[4:2] != 3'h0) |->
      o_precomp_step == {1'b0, rps_r[4:2]}) else $error("precomp step");
   a_pc_def1m: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (rps_r[4:2] == 3'h0 && o_rate_code == fhr_pkg::FHR_R1M) |->
      o_precomp_step == `FHR_PC_DEF1M) else $error("precomp 1m");
   a_pc_defoth: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (rps_r[4:2] == 3'h0 && o_rate_code != fhr_pkg::FHR_R1M) |->
      o_precomp_step == `FHR_PC_DEF) else $error("precomp default");

   // separator divider follows the active rate at all times
   a_sep_500k: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_rate_code == fhr_pkg::FHR_R500K |-> o_sep_clk_div == `FHR_DIV_500K)
      else $error("divider 500k");
   a_sep_300k: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_rate_code == fhr_pkg::FHR_R300K |-> o_sep_clk_div == `FHR_DIV_300K)
      else $error("divider 300k");
   a_sep_250k: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_rate_code == fhr_pkg::FHR_R250K |-> o_sep_clk_div == `FHR_DIV_250K)
      else $error("divider 250k");
   a_sep_1m: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_rate_code == fhr_pkg::FHR_R1M |-> o_sep_clk_div == `FHR_DIV_1M)
      else $error("divider 1m");

   // rate comes from the newest write of either register
   a_rate_rps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_rps |=> o_rate_code == $past(wd[1:0]))
      else $error("rate select not taken");
   a_rate_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (!wr_rps && !wr_drc) |=> $stable(o_rate_code))
      else $error("rate moved without write");

   // every reset source holds the engine; free only when none is active
   a_bus_core: assert property (@(posedge i_clk)
      i_sys_rst |=> o_core_reset)
      else $error("bus reset missed core");
   a_crst_rate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rrst_r |-> o_core_reset)
      else $error("rate reset missed core");
   a_crst_doc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !doc_r[`FHR_B_CRST] |-> o_core_reset)
      else $error("control reset missed core");
   a_crst_free: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (doc_r[`FHR_B_CRST] && !rrst_r) |-> !o_core_reset)
      else $error("core held for nothing");
   a_rrst_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (wr_rps && wd[`FHR_B_RST]) |=> rrst_r)
      else $error("rate reset not taken");

   // software resets leave the host registers alone, but clear power-down
   a_doc_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !wr_doc |=> $stable(doc_r))
      else $error("output control moved");
   a_rps_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !wr_rps |=> $stable(rps_r))
      else $error("rate select moved");
   a_tsc_store: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_tsc |=> tsc_r == $past(wd[1:0]))
      else $error("tape pick not stored");

   // drive bits and the interrupt / dma gate
   a_mot2_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_doc |=> o_second_motor_enable == $past(wd[`FHR_B_MOTB]))
      else $error("second motor wrong");
   a_pick_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_doc |=> o_drive_pick == $past(wd[`FHR_B_PICK]))
      else $error("drive pick wrong");
   a_irq_pass: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      doc_r[`FHR_B_GATE] |-> o_irq == i_core_irq)
      else $error("irq not passed");
   a_drq_pass: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      doc_r[`FHR_B_GATE] |-> o_drq == i_core_drq)
      else $error("drq not passed");

   // one stack entry per access, never both ways at once
   a_push_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_stack_push |=> !o_stack_push)
      else $error("double push");
   a_pop_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_stack_pop |=> !o_stack_pop)
      else $error("double pop");
   a_push_pop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !(o_stack_push && o_stack_pop))
      else $error("push and pop together");

   // power-down entry and wake
   a_pwr_data: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (rd_dat || wr_dat) |=> !o_power_down)
      else $error("no wake on data access");
   a_pwr_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (wr_rps && wd[`FHR_B_PWR]) |=> o_power_down)
      else $error("power down not entered");

   // read side of shared and unmapped offsets, status bit map
   a_rd_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (rd_go && idx == `FHR_IDX_DRV) |=> o_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_dchg_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (rd_go && idx == `FHR_IDX_DIS) |=> o_readdata[7] == !$past(dchg_s2))
      else $error("disk change bit wrong");
   a_wait_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_write && !ack_r) |=> !o_waitrequest)
      else $error("late write answer");
   a_mst_dir: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rd_mst |=> o_readdata[6] == $past(i_transfer_direction_flag))
      else $error("status bit 6 wrong");
   a_mst_ndm: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rd_mst |=> o_readdata[5] == $past(i_non_dma_flag))
      else $error("status bit 5 wrong");
   a_mst_cb: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rd_mst |=> o_readdata[4] == $past(i_command_busy_flag))
      else $error("status bit 4 wrong");
   a_mst_seekb: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rd_mst |=> o_readdata[1] == $past(i_second_drive_seek_busy))
      else $error("status bit 1 wrong");
   a_mst_seeka: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      rd_mst |=> o_readdata[0] == $past(i_first_drive_seek_busy))
      else $error("status bit 0 wrong");

   // values seen at the first edge after the bus reset lets go
   a_rate_init: assert property (@(posedge i_clk)
      $fell(i_sys_rst) |-> o_rate_code == fhr_pkg::FHR_R250K)
      else $error("rate not 250k after reset");
   a_pc_init: assert property (@(posedge i_clk)
      $fell(i_sys_rst) |-> o_precomp_step == `FHR_PC_DEF)
      else $error("precomp not default after reset");
   a_doc_init: assert property (@(posedge i_clk)
      $fell(i_sys_rst) |-> o_core_reset && !o_first_motor_enable)
      else $error("output control not cleared");
endmodule // fhr_regs

// ---- bench/fhr_host.sv ----
// Purpose: host processor model making byte accesses over avalon-mm
// Assumes: slave ends each access by waitrequest low, latency not fixed
// Notes: signals change by nba just after a rising edge
`timescale 1ns/100ps
module fhr_host (
   // clock
   input wire logic i_clk,
   // avalon-mm master side
   input wire logic [31:0] i_readdata,
   input wire logic i_waitrequest,
   output logic [4:0] o_address,
   output logic o_read,
   output logic o_write,
   output logic [31:0] o_writedata,
   output logic [3:0] o_byteenable
);
   // idle bus at time zero, only byte lane 0 carries data
   initial begin
      o_address = 5'h00;
      o_read = 1'b0;
      o_write = 1'b0;
      o_writedata = 32'h0;
      o_byteenable = 4'h1;
   end
   // one access; waitrequest and read data are taken at rising edges,
   // before that edge's updates land, and released at the same edge
   task automatic xfer(input logic w, input logic [4:0] a,
         input logic [7:0] d, output logic [7:0] q);
      @(posedge i_clk);
      o_address <= a;
      o_write <= w;
      o_read <= ~w;
      o_writedata <= {24'h0, d};
      @(posedge i_clk);
      while (i_waitrequest !== 1'b0) @(posedge i_clk);
      q = i_readdata[7:0];
      o_read <= 1'b0;
      o_write <= 1'b0;
      o_writedata <= ~o_writedata; // released data is not left valid
   endtask
endmodule // fhr_host

// ---- bench/floppy_host_register_interface_bench.sv ----
// Purpose: self-checking bench for the floppy host register set
// Assumes: each access answered by one waitrequest cycle
// Notes: byte address is four times the register offset
`timescale 1ns/100ps
module floppy_host_register_interface_bench;
   logic clk, rst, rq, dir, non_dma_flag, cb, sb, fb, dchg_n, irq_in, drq_in;
   logic rd, wr, wreq, crst, pop, push, pwd, m1, m2, pick, irq, drq;
   logic [4:0] adr;
   logic [31:0] wdat, rdat;
   logic [3:0] be, sdiv, pstep;
   logic [7:0] stk, pdat, q, last_push;
   logic [1:0] rcode;
   int failures = 0, total_checks = 0, pops, pushes, rst_cyc;
   fhr_regs dut (.i_clk(clk), .i_sys_rst(rst), .i_address(adr),
      .i_read(rd), .i_write(wr), .i_writedata(wdat), .i_byteenable(be),
      .o_readdata(rdat), .o_waitrequest(wreq),
      .i_transfer_request_flag(rq), .i_transfer_direction_flag(dir),
      .i_non_dma_flag(non_dma_flag), .i_command_busy_flag(cb),
      .i_second_drive_seek_busy(sb), .i_first_drive_seek_busy(fb),
      .i_stack_rd_data(stk), .i_disk_change_n(dchg_n),
      .i_core_irq(irq_in), .i_core_drq(drq_in), .o_core_reset(crst),
      .o_stack_pop(pop), .o_stack_push(push), .o_stack_wr_data(pdat),
      .o_rate_code(rcode), .o_sep_clk_div(sdiv), .o_precomp_step(pstep),
      .o_power_down(pwd), .o_first_motor_enable(m1),
      .o_second_motor_enable(m2), .o_drive_pick(pick), .o_irq(irq),
      .o_drq(drq));
   fhr_host h (.i_clk(clk), .i_readdata(rdat), .i_waitrequest(wreq),
      .o_address(adr), .o_read(rd), .o_write(wr), .o_writedata(wdat),
      .o_byteenable(be));
   // clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // count pulse cycles; a one-cycle pulse must show as exactly one
   always @(posedge clk) begin
      if (crst) rst_cyc <= rst_cyc + 1;
      if (pop) pops <= pops + 1;
      if (push) pushes <= pushes + 1;
      if (push) last_push <= pdat;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic w(input logic [4:0] a, input logic [7:0] d);
      h.xfer(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [4:0] a, input logic [7:0] m,
         input logic [7:0] e);
      h.xfer(1'b0, a, 8'h00, q);
      chk(q & m, e);
   endtask
   // expected precomp step: 7 means none, 0 the rate default
   function automatic logic [3:0] pc(input logic [2:0] p, input logic [1:0] r);
      if (p == 3'h7) return 4'h0;
      if (p != 3'h0) return {1'b0, p};
      return (r == 2'h3) ? 4'h1 : 4'h3;
   endfunction
   task automatic test_done;
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // watchdog, far beyond the fewer than two hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      test_done;
   end
   initial begin
      rst = 1'b1;
      stk = 8'ha5;
      {rq, dir, non_dma_flag, cb, sb, fb} = 6'h00;
      {dchg_n, irq_in, drq_in} = 3'h7;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk({crst, irq, rcode, sdiv, pstep}, 12'ha33);
      rc(5'h08, 8'hff, 8'h00);
      rc(5'h00, 8'hff, 8'h00);
      rc(5'h18, 8'hff, 8'h00);
      w(5'h0c, 8'h03);
      rc(5'h0c, 8'h03, 8'h03);
      w(5'h08, 8'h3d);
      chk({m2, m1, pick, crst, irq, drq}, 6'b111011);
      w(5'h08, 8'h35);
      chk({crst, irq, drq}, 3'h0);
      for (int i = 0; i < 32; i++) begin
         w(5'h10, {3'h0, i[2:0], i[4:3]});
         chk({rcode, sdiv, pstep}, {i[4:3], 2'h0, i[4:3] + 2'h1,
            pc(i[2:0], i[4:3])});
      end
      w(5'h1c, 8'hfd);
      chk({rcode, sdiv}, 6'h12);
      dchg_n <= 1'b0;
      repeat (2) @(posedge clk); // the pin passes two flops
      rc(5'h1c, 8'h80, 8'h80);
      w(5'h08, 8'h39);
      rc(5'h08, 8'hff, 8'h39);
      chk({crst, rcode}, 3'h5);
      rst_cyc = 0;
      w(5'h10, 8'h82);
      chk(crst, 1'b1);
      w(5'h08, 8'h3d);
      rst_cyc = 0;
      w(5'h10, 8'h82);
      repeat (3) @(posedge clk);
      chk({rst_cyc[3:0], crst, rcode}, 7'h0a);
      {rq, dir, non_dma_flag, cb, sb, fb} <= 6'b110110;
      rc(5'h10, 8'hf3, 8'hd2);
      {rq, dir, non_dma_flag, cb, sb, fb} <= 6'b001001;
      w(5'h10, 8'h42);
      chk(pwd, 1'b1);
      rc(5'h10, 8'hf3, 8'h21);
      chk(pwd, 1'b0);
      pops = 0;
      pushes = 0;
      w(5'h14, 8'h5a);
      rc(5'h14, 8'hff, 8'ha5);
      chk({pops[1:0], pushes[1:0], last_push}, 12'h55a);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk({crst, m1, rcode}, 4'ha);
      rc(5'h08, 8'hff, 8'h00);
      test_done;
   end
endmodule // floppy_host_register_interface_bench
